// *** hk_defines.svh ***
// Purpose: Offsets, field positions, keys and timing figures of the housekeeping registers
// Assumes: Word-indexed register port, 9-bit register index
// Notes: Definitions only
`ifndef HK_DEFINES_SVH
`define HK_DEFINES_SVH

`define ADDR_W 9
`define OFS_STATUS 9'h0CA
`define OFS_CHECKSUM 9'h109
`define OFS_SWRESET 9'h1BE
`define OFS_FLAG_CLEAR 9'h19D
`define OFS_IRQ_STATUS 9'h1A0
`define OFS_IRQ_MASK 9'h1A1
`define OFS_PROT_BASE 9'h0F2
`define PROT_COUNT 23
`define PROT_AW 5

`define RESET_KEY 32'h4572_BEAF
`define SUM_PASS 32'hFFFF_FFFF
`define TEST_PATTERN 32'hA5A5_5A5A
`define WORD_ZERO 32'h0000_0000

`define BIT_POLARITY 11
`define BIT_PHASE_LATCH 9
`define BIT_SELFTEST 8
`define BIT_SUPPLY_LIVE 7
`define BIT_SUPPLY_LATCH 6
`define CAUSE_HI 5
`define CAUSE_LO 3
`define BIT_CHECK_FAIL 2
`define BIT_PHASE_LIVE 1

`define CAUSE_NONE 3'h0
`define CAUSE_POR 3'h1
`define CAUSE_RX 3'h3
`define CAUSE_SOFT 3'h4

`define IRQ_W 4
`define IRQ_PHASE 0
`define IRQ_SUPPLY 1
`define IRQ_CHECK 2
`define IRQ_SELFTEST 3

`define SYS_CLK_MHZ 50
`define CHECK_TIME_US 5000
`define SELFTEST_TIME_US 1250

`endif

// *** hk_pkg.sv ***
// Purpose: Types shared by the housekeeping block
// Assumes: Constants live in hk_defines.svh
// Notes: None
`default_nettype none
package hk_pkg;
  typedef enum logic [2:0] {
    ST_FILL, ST_CHECK, ST_CHECK_END, ST_CLEAR, ST_IDLE, ST_SCAN, ST_SCAN_END
  } hk_state_t;
  typedef logic [2:0] reset_cause_t;
endpackage : hk_pkg
`default_nettype wire

// *** prot_mem.sv ***
// Purpose: Storage for the protected configuration words
// Assumes: One write port and one read port on the same clock
// Notes: Read data come from a register one cycle after the read enable
`default_nettype none
module prot_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 23,
  parameter int AW = 5
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (clk_en && rd_en) begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule : prot_mem
`default_nettype wire

// *** config_check_reset_status.sv ***
// Purpose: Configuration checksum, keyed software reset and system status word
// Assumes: Sense inputs and the receive-line reset are asynchronous to sys_clk
// Notes: Protected words are write-only through this port and read as zero
//
// Strobed register access was decided locally.
`include "hk_defines.svh"
`default_nettype none
// Contract
// - Sum checksum and protected words; check passes only when the sum is all ones.
// - Status bit 2 reads 0 on a passing sum, 1 otherwise.
// - The check is re-run and bit 2 refreshed every 5 ms.
// - Writing the key to the reset register resets the whole system.
// - Checksum register is 32-bit read/write, reset to zero.
// - Status bit 11 follows the voltage sign and cannot be cleared.
// - Status bit 1 shows the live phase-done indication.
// - Status bit 9 latches phase completion.
// - After each global reset the RAM self-test runs and ends within 1.25 ms.
// - Status bit 8 reads 1 when the RAM self-test failed.
// - Status bit 7 shows the live supply-low comparator.
// - Status bit 6 latches a supply-low event and keeps it until flag-clear register bit 6 is written.
// - Status bits 5..3 give reset cause: 001 power-on, 011 receive line, 100 software.
// - Flag-clear register bit 9 clears the latched phase-done flag.
// - Every reset kind returns the control registers to defaults.
module config_check_reset_status #(
  parameter int CHECK_CYCLES = `CHECK_TIME_US * `SYS_CLK_MHZ,
  parameter int SELFTEST_LIMIT = `SELFTEST_TIME_US * `SYS_CLK_MHZ
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Asynchronous sense inputs
  input wire logic rx_line_reset,
  input wire logic voltage_polarity,
  input wire logic phase_done_live,
  input wire logic supply_low_live,
  // System outputs
  output logic system_reset,
  output logic irq,
  output hk_pkg::reset_cause_t last_reset_cause
);
  import hk_pkg::*;
  localparam int CW = $clog2(CHECK_CYCLES + 1);
  localparam int BW = $clog2(SELFTEST_LIMIT + 2);
  localparam int NS = 4;
  localparam int S_RX = 0;
  localparam int S_POL = 1;
  localparam int S_PH = 2;
  localparam int S_SUP = 3;
  localparam logic [`PROT_AW-1:0] LAST_IDX = `PROT_AW'(`PROT_COUNT - 1);
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  logic rx_prev_reg;
  logic ph_prev_reg;
  logic sup_prev_reg;
  hk_state_t state_reg;
  hk_state_t state_next;
  logic [`PROT_AW-1:0] idx_reg;
  logic [`PROT_AW-1:0] idx_next;
  logic pend_reg;
  logic [31:0] sum_reg;
  logic [31:0] checksum_reg;
  logic [31:0] swreset_reg;
  logic config_check_fail_reg;
  logic selftest_fail_reg;
  logic phase_latch_reg;
  logic supply_latch_reg;
  logic [`IRQ_W-1:0] irq_status_reg;
  logic [`IRQ_W-1:0] irq_mask_reg;
  logic [CW-1:0] period_reg;
  logic [BW-1:0] bist_cyc_reg;
  logic [31:0] status_word;
  logic [31:0] mem_rdata;
  // Input synchronisers, one per asynchronous sense line
  wire logic [NS-1:0] async_in = {supply_low_live, phase_done_live, voltage_polarity,
                                  rx_line_reset};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  // Decode
  wire logic wr_checksum = reg_wr && reg_addr == `OFS_CHECKSUM;
  wire logic wr_swreset = reg_wr && reg_addr == `OFS_SWRESET;
  wire logic wr_flag_clear = reg_wr && reg_addr == `OFS_FLAG_CLEAR;
  wire logic wr_irq_status = reg_wr && reg_addr == `OFS_IRQ_STATUS;
  wire logic wr_irq_mask = reg_wr && reg_addr == `OFS_IRQ_MASK;
  wire logic [`ADDR_W-1:0] prot_off = reg_addr - `OFS_PROT_BASE;
  wire logic prot_hit = reg_addr >= `OFS_PROT_BASE &&
                        prot_off < `ADDR_W'(`PROT_COUNT);
  wire logic bist_busy = state_reg inside {ST_FILL, ST_CHECK, ST_CHECK_END, ST_CLEAR};
  wire logic soft_evt = wr_swreset && reg_wdata == `RESET_KEY;
  wire logic rx_evt = sync2_reg[S_RX] && !rx_prev_reg;
  wire logic clr = system_reset;
  wire logic ph_rise = sync2_reg[S_PH] && !ph_prev_reg;
  wire logic sup_rise = sync2_reg[S_SUP] && !sup_prev_reg;
  wire logic period_hit = period_reg == '0;
  wire logic [31:0] sum_final = sum_reg + mem_rdata;
  wire logic test_mismatch = pend_reg && mem_rdata != `TEST_PATTERN &&
                             (state_reg == ST_CHECK || state_reg == ST_CHECK_END);
  wire logic [`IRQ_W-1:0] irq_events = {`IRQ_W{1'b0}} |
    (`IRQ_W'(ph_rise) << `IRQ_PHASE) | (`IRQ_W'(sup_rise) << `IRQ_SUPPLY) |
    (`IRQ_W'(state_reg == ST_SCAN_END && sum_final != `SUM_PASS) << `IRQ_CHECK) |
    (`IRQ_W'(test_mismatch) << `IRQ_SELFTEST);
  // Memory port steering; self-test owns the write port while it runs
  wire logic mem_we = state_reg inside {ST_FILL, ST_CLEAR} || (reg_wr && prot_hit && !bist_busy);
  wire logic [`PROT_AW-1:0] mem_waddr = bist_busy ? idx_reg : prot_off[`PROT_AW-1:0];
  wire logic [31:0] mem_wdata = state_reg == ST_FILL ? `TEST_PATTERN :
                                state_reg == ST_CLEAR ? `WORD_ZERO : reg_wdata;
  wire logic mem_re = state_reg == ST_CHECK || state_reg == ST_SCAN;
  prot_mem #(.WIDTH(32), .DEPTH(`PROT_COUNT), .AW(`PROT_AW)) u_mem (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_en(mem_re),
    .rd_addr(idx_reg),
    .rd_data(mem_rdata)
  );
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    case (state_reg)
      ST_FILL, ST_CLEAR: begin
        idx_next = idx_reg + `PROT_AW'(1);
        if (idx_reg == LAST_IDX) begin
          idx_next = '0;
          state_next = state_reg == ST_FILL ? ST_CHECK : ST_IDLE;
        end
      end
      ST_CHECK, ST_SCAN: begin
        idx_next = idx_reg + `PROT_AW'(1);
        if (idx_reg == LAST_IDX) begin
          idx_next = '0;
          state_next = state_reg == ST_CHECK ? ST_CHECK_END : ST_SCAN_END;
        end
      end
      ST_CHECK_END: state_next = ST_CLEAR;
      ST_IDLE: begin
        if (period_hit) begin
          state_next = ST_SCAN;
        end
      end
      ST_SCAN_END: state_next = ST_IDLE;
      default: state_next = ST_FILL;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      state_reg <= ST_FILL;
      idx_reg <= '0;
      pend_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      pend_reg <= mem_re;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      period_reg <= CW'(CHECK_CYCLES - 1);
    end else if (clk_en && !bist_busy) begin
      period_reg <= period_hit ? CW'(CHECK_CYCLES - 1) : period_reg - CW'(1);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sum_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == ST_IDLE && period_hit) begin
        sum_reg <= checksum_reg;
      end else if (pend_reg && (state_reg == ST_SCAN || state_reg == ST_SCAN_END)) begin
        sum_reg <= sum_final;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      config_check_fail_reg <= 1'b0;
    end else if (clk_en && state_reg == ST_SCAN_END) begin
      config_check_fail_reg <= sum_final != `SUM_PASS;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      selftest_fail_reg <= 1'b0;
    end else if (clk_en && test_mismatch) begin
      selftest_fail_reg <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      checksum_reg <= '0;
      swreset_reg <= '0;
    end else if (clk_en) begin
      if (wr_checksum) begin
        checksum_reg <= reg_wdata;
      end
      if (wr_swreset) begin
        swreset_reg <= reg_wdata;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      system_reset <= 1'b0;
      rx_prev_reg <= 1'b0;
      ph_prev_reg <= 1'b0;
      sup_prev_reg <= 1'b0;
    end else if (clk_en) begin
      system_reset <= soft_evt || rx_evt;
      rx_prev_reg <= sync2_reg[S_RX];
      ph_prev_reg <= sync2_reg[S_PH];
      sup_prev_reg <= sync2_reg[S_SUP];
    end
  end
  // Reset cause survives the system reset it reports
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_reset_cause <= `CAUSE_POR;
    end else if (clk_en && rx_evt) begin
      last_reset_cause <= `CAUSE_RX;
    end else if (clk_en && soft_evt) begin
      last_reset_cause <= `CAUSE_SOFT;
    end
  end
  // Latched flags; a set in the clear cycle wins
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      phase_latch_reg <= 1'b0;
      supply_latch_reg <= 1'b0;
    end else if (clk_en) begin
      phase_latch_reg <= sync2_reg[S_PH] ||
        (phase_latch_reg && !(wr_flag_clear && reg_wdata[`BIT_PHASE_LATCH]));
      supply_latch_reg <= sync2_reg[S_SUP] ||
        (supply_latch_reg && !(wr_flag_clear && reg_wdata[`BIT_SUPPLY_LATCH]));
    end
  end
  // Interrupt status, write one to clear, event wins
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      irq_status_reg <= irq_events |
        (irq_status_reg & ~(wr_irq_status ? reg_wdata[`IRQ_W-1:0] : '0));
      if (wr_irq_mask) begin
        irq_mask_reg <= reg_wdata[`IRQ_W-1:0];
      end
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end
  // Status word; reserved bits read zero
  always_comb begin
    status_word = '0;
    status_word[`BIT_POLARITY] = sync2_reg[S_POL];
    status_word[`BIT_PHASE_LATCH] = phase_latch_reg;
    status_word[`BIT_SELFTEST] = selftest_fail_reg;
    status_word[`BIT_SUPPLY_LIVE] = sync2_reg[S_SUP];
    status_word[`BIT_SUPPLY_LATCH] = supply_latch_reg;
    status_word[`CAUSE_HI:`CAUSE_LO] = last_reset_cause;
    status_word[`BIT_CHECK_FAIL] = config_check_fail_reg;
    status_word[`BIT_PHASE_LIVE] = sync2_reg[S_PH];
  end
  wire logic [31:0] rd_mux =
    reg_addr == `OFS_STATUS ? status_word :
    reg_addr == `OFS_CHECKSUM ? checksum_reg :
    reg_addr == `OFS_SWRESET ? swreset_reg :
    reg_addr == `OFS_IRQ_STATUS ? 32'(irq_status_reg) :
    reg_addr == `OFS_IRQ_MASK ? 32'(irq_mask_reg) : `WORD_ZERO;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : `WORD_ZERO;
    end
  end
  // Self-test duration, helper for checking only
  always_ff @(posedge sys_clk) begin
    if (srst || (clk_en && clr)) begin
      bist_cyc_reg <= '0;
    end else if (clk_en && bist_busy && bist_cyc_reg != BW'(SELFTEST_LIMIT + 1)) begin
      bist_cyc_reg <= bist_cyc_reg + BW'(1);
    end
  end
  chk_value_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && !clr && state_reg == ST_SCAN_END)
    |=> config_check_fail_reg == $past(sum_final != `SUM_PASS))
    else $error("check flag does not match sum");
  chk_update_a: assert property (@(posedge sys_clk) disable iff (srst)
    $changed(config_check_fail_reg) |-> $past(state_reg == ST_SCAN_END || clr))
    else $error("check flag changed outside a refresh");
  key_reset_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && wr_swreset && reg_wdata == `RESET_KEY)
    |=> system_reset ##1 (!clk_en || state_reg == ST_FILL))
    else $error("key write did not reset");
  nonkey_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && wr_swreset && reg_wdata != `RESET_KEY && !rx_evt) |=> !system_reset)
    else $error("non-key write caused reset");
  config_checksum_reset_a: assert property (@(posedge sys_clk)
    srst |=> checksum_reg == `WORD_ZERO)
    else $error("checksum not zero after reset");
  phase_latch_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && !clr && sync2_reg[S_PH]) |=> phase_latch_reg)
    else $error("phase completion not latched");
  supply_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && !clr && supply_latch_reg && !wr_flag_clear) |=> supply_latch_reg)
    else $error("supply-low latch lost");
  bist_time_a: assert property (@(posedge sys_clk) disable iff (srst)
    bist_cyc_reg <= BW'(SELFTEST_LIMIT))
    else $error("self-test too long");
  cause_soft_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && soft_evt && !rx_evt) |=> last_reset_cause == `CAUSE_SOFT)
    else $error("software reset cause wrong");
  read_clean_a: assert property (@(posedge sys_clk) disable iff (srst)
    (clk_en && !clr && reg_rd && !reg_wr) |=> !$fell(phase_latch_reg) && !$fell(supply_latch_reg))
    else $error("read altered a latched flag");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (srst)
    $past(clk_en) && !$past(clr) |-> irq == $past(|(irq_status_reg & irq_mask_reg)))
    else $error("interrupt level wrong");
  soft_reset_c: cover property (@(posedge sys_clk) disable iff (srst) soft_evt && clk_en);
  check_fail_c: cover property (@(posedge sys_clk) disable iff (srst)
    $rose(config_check_fail_reg));
  scan_done_c: cover property (@(posedge sys_clk) disable iff (srst)
    clk_en && state_reg == ST_SCAN_END);
  irq_c: cover property (@(posedge sys_clk) disable iff (srst) $rose(irq));
endmodule : config_check_reset_status
`default_nettype wire

// *** hk_host_model.sv ***
// Purpose: Host software side of the housekeeping register port
// Assumes: One access at a time, each started just after a rising edge
// Notes: Released address and data lines carry the inverse of the last value
`include "hk_defines.svh"
`default_nettype none
module hk_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [`ADDR_W-1:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bits that carry meaning in the status word
  localparam logic [31:0] STATUS_USED = 32'h0000_0BFE;

  initial begin
    reg_addr = 9'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic write_word(input logic [`ADDR_W-1:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask : write_word

  // Data stand only in the cycle after the read edge, so sample mid-cycle
  task automatic read_word(input logic [`ADDR_W-1:0] addr, output logic [31:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    @(negedge sys_clk);
    data = reg_rdata;
  endtask : read_word

  task automatic read_status(output logic [31:0] data);
    read_word(`OFS_STATUS, data);
    data = data & STATUS_USED;
  endtask : read_status

  function automatic logic [31:0] checksum_for(input logic [31:0] words[$]);
    logic [31:0] sum;
    sum = 32'h0000_0000;
    foreach (words[i]) sum = sum + words[i];
    return `SUM_PASS - sum;
  endfunction : checksum_for

  task automatic send_reset_key();
    write_word(`OFS_SWRESET, `RESET_KEY);
  endtask : send_reset_key
endmodule : hk_host_model
`default_nettype wire

// *** config_check_reset_status_tb_top.sv ***
// Purpose: Self-checking bench for the housekeeping register block
// Assumes: Short check period; sense pins low whenever a reset is requested
// Notes: Expected status words come from a small model held in the bench
`include "hk_defines.svh"
`default_nettype none
module config_check_reset_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CHECK_N = 200;
  localparam int SCAN_WAIT = 2 * CHECK_N + 60;

  logic sys_clk;
  logic srst;
  logic clk_en;
  logic [`ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic rx_line_reset;
  logic voltage_polarity;
  logic phase_done_live;
  logic supply_low_live;
  logic system_reset;
  logic irq;
  hk_pkg::reset_cause_t last_reset_cause;
  int num_errors;
  int samples_checked;
  int m_cause;
  bit m_pol, m_ph, m_ph_lat, m_sl, m_sl_lat, m_fail;
  logic [31:0] m_ck;
  logic [31:0] m_words[$];
  logic [31:0] rd;
  logic [31:0] v;
  logic [31:0] sum;

  config_check_reset_status #(.CHECK_CYCLES(CHECK_N), .SELFTEST_LIMIT(100)) DUT (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_line_reset(rx_line_reset),
    .voltage_polarity(voltage_polarity), .phase_done_live(phase_done_live),
    .supply_low_live(supply_low_live), .system_reset(system_reset), .irq(irq),
    .last_reset_cause(last_reset_cause)
  );

  hk_host_model host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [31:0] exp_status();
    logic [31:0] s;
    s = 32'h0000_0000;
    s[`BIT_POLARITY] = m_pol;
    s[`BIT_PHASE_LATCH] = m_ph_lat;
    s[`BIT_SUPPLY_LIVE] = m_sl;
    s[`BIT_SUPPLY_LATCH] = m_sl_lat;
    s[`CAUSE_HI:`CAUSE_LO] = m_cause[2:0];
    s[`BIT_CHECK_FAIL] = m_fail;
    s[`BIT_PHASE_LIVE] = m_ph;
    return s;
  endfunction : exp_status

  task automatic model_reset(input int cause);
    m_cause = cause;
    m_ph_lat = 0;
    m_sl_lat = 0;
    m_fail = 0;
    m_ck = 32'h0000_0000;
  endtask : model_reset

  task automatic set_sense(input bit pol, input bit ph, input bit sl);
    @(posedge sys_clk);
    voltage_polarity <= pol;
    phase_done_live <= ph;
    supply_low_live <= sl;
    m_pol = pol;
    m_ph = ph;
    m_sl = sl;
    m_ph_lat |= ph;
    m_sl_lat |= sl;
    repeat (5) @(posedge sys_clk);
  endtask : set_sense

  task automatic status_is();
    host.read_status(rd);
    check(rd, exp_status());
  endtask : status_is

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  initial begin
    num_errors = 0;
    samples_checked = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    rx_line_reset = 1'b0;
    voltage_polarity = 1'b0;
    phase_done_live = 1'b0;
    supply_low_live = 1'b0;
    m_pol = 0;
    m_ph = 0;
    m_sl = 0;
    model_reset(`CAUSE_POR);
    v = $urandom(32'hcbab);
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (80) @(posedge sys_clk);
    status_is();
    host.read_word(`OFS_CHECKSUM, rd);
    check(rd, 32'h0000_0000);
    host.read_word(`OFS_SWRESET, rd);
    check(rd, 32'h0000_0000);
    host.read_word(9'h1FF, rd);
    check(rd, 32'h0000_0000);
    v = $urandom();
    host.write_word(`OFS_CHECKSUM, v);
    host.read_word(`OFS_CHECKSUM, rd);
    check(rd, v);
    $display("test reset_and_access done");
    set_sense(1, 1, 1);
    status_is();
    set_sense(0, 0, 0);
    status_is();
    status_is();
    host.write_word(`OFS_FLAG_CLEAR, 32'h0000_0200);
    m_ph_lat = 0;
    status_is();
    host.write_word(`OFS_FLAG_CLEAR, 32'h0000_0040);
    m_sl_lat = 0;
    status_is();
    $display("test flags done");
    m_words.delete();
    sum = 32'h0000_0000;
    for (int i = 0; i < `PROT_COUNT; i++) begin
      v = $urandom();
      m_words.push_back(v);
      sum = sum + v;
      host.write_word(`OFS_PROT_BASE + 9'(i), v);
    end
    m_ck = host.checksum_for(m_words);
    host.write_word(`OFS_CHECKSUM, m_ck);
    repeat (SCAN_WAIT) @(posedge sys_clk);
    m_fail = ((sum + m_ck) != 32'hFFFF_FFFF);
    status_is();
    m_ck = m_ck + 32'h0000_0001;
    host.write_word(`OFS_CHECKSUM, m_ck);
    repeat (SCAN_WAIT) @(posedge sys_clk);
    m_fail = ((sum + m_ck) != 32'hFFFF_FFFF);
    status_is();
    $display("test config_check done");
    host.write_word(`OFS_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    #1 check({31'h0, irq}, 32'h0000_0001);
    host.read_word(`OFS_IRQ_STATUS, rd);
    check(rd & 32'h0000_0007, 32'h0000_0007);
    host.write_word(`OFS_IRQ_STATUS, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    #1 check({31'h0, irq}, 32'h0000_0000);
    host.write_word(`OFS_IRQ_MASK, 32'h0000_0002);
    repeat (3) @(posedge sys_clk);
    #1 check({31'h0, irq}, 32'h0000_0001);
    host.write_word(`OFS_IRQ_STATUS, 32'h0000_0002);
    repeat (3) @(posedge sys_clk);
    #1 check({31'h0, irq}, 32'h0000_0000);
    $display("test interrupt done");
    v = $urandom();
    if (v == `RESET_KEY) v = v ^ 32'h0000_0001;
    host.write_word(`OFS_SWRESET, v);
    #1 check({31'h0, system_reset}, 32'h0000_0000);
    host.read_word(`OFS_SWRESET, rd);
    check(rd, v);
    host.read_word(`OFS_CHECKSUM, rd);
    check(rd, m_ck);
    host.send_reset_key();
    #1 check({31'h0, system_reset}, 32'h0000_0001);
    check({29'h0, last_reset_cause}, 32'(`CAUSE_SOFT));
    model_reset(`CAUSE_SOFT);
    repeat (80) @(posedge sys_clk);
    status_is();
    host.read_word(`OFS_CHECKSUM, rd);
    check(rd, 32'h0000_0000);
    host.read_word(`OFS_IRQ_MASK, rd);
    check(rd, 32'h0000_0000);
    $display("test soft_reset done");
    @(posedge sys_clk);
    rx_line_reset <= 1'b1;
    v = 0;
    while (system_reset !== 1'b1 && v < 10) begin
      @(posedge sys_clk);
      #1 v = v + 1;
    end
    if (v >= 10) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, system_reset, 1'b1);
      final_report();
    end
    @(posedge sys_clk);
    rx_line_reset <= 1'b0;
    model_reset(`CAUSE_RX);
    repeat (80) @(posedge sys_clk);
    status_is();
    check({29'h0, last_reset_cause}, 32'(`CAUSE_RX));
    // A write while the enable is low must leave no trace
    @(posedge sys_clk);
    clk_en <= 1'b0;
    host.write_word(`OFS_CHECKSUM, ~m_ck);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    host.read_word(`OFS_CHECKSUM, rd);
    check(rd, m_ck);
    $display("test rx_reset done");
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    model_reset(`CAUSE_POR);
    repeat (80) @(posedge sys_clk);
    status_is();
    $display("test power_on_again done");
    final_report();
  end
endmodule : config_check_reset_status_tb_top
`default_nettype wire
